// >>> common/wdp_pkg.sv
/*
 * Constants and types of the watchdog timer with prescaler.
 * Assumes a single 250 MHz system clock and an AHB-Lite register port.
 */
// Behaviour
// RULE1 - Counter advances on a separate RC oscillator, also while the core sleeps.
// RULE2 - Time-out while running requests a full watchdog-type device reset.
// RULE3 - Time-out while asleep wakes the device instead of resetting it.
// RULE4 - Enable fuse at zero disables the watchdog for good; software cannot enable.
// RULE5 - Undivided time-out period is nominally 18 ms of oscillator time.
// RULE6 - Control register assigns a prescaler of up to 1:128 to the watchdog.
// RULE7 - Clear or sleep instruction restarts count, and prescaler when assigned.
// RULE8 - Every time-out clears the active-low time-out flag.
// RULE9 - Software clears the watchdog before changing ratio while assigned.
// RULE10 - Ratio field selects powers of two; unassigned prescaler leaves count undivided.
`default_nettype none

package wdp_pkg;

    // Oscillator rate is nominal and arbitrary; only the period is given
    localparam int unsigned RC_OSC_KHZ = 1000;
    localparam int unsigned BASE_PERIOD_US = 18000;
    localparam int unsigned BASE_TICKS = BASE_PERIOD_US * RC_OSC_KHZ / 1000;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PRESCALE_CTRL = 8'h81;
    localparam logic [7:0] IDX_WD_STATUS = 8'h82;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h84;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h85;
    localparam logic [7:0] IDX_COUNT = 8'h86;

    localparam logic [7:0] PRESCALE_CTRL_RESET = 8'hff;
    localparam int unsigned ASSIGN_BIT = 3;
    localparam int unsigned RATIO_LSB = 0;
    localparam int unsigned RATIO_W = 3;
    localparam int unsigned PRE_W = 7;

    localparam int unsigned ST_TIMEOUT_N = 0;
    localparam int unsigned ST_ASLEEP = 1;
    localparam int unsigned ST_ENABLED = 2;

    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_RESET = 0;
    localparam int unsigned IRQ_WAKE = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET_VAL = 2'h0;

    localparam logic [21:0] HADDR_HIGH_ZERO = 22'h0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] STARTUP_DONE = 2'h3;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0001,
        BUS_WRITE = 4'b0010,
        BUS_RWAIT = 4'b0100,
        BUS_RDONE = 4'b1000
    } wdp_bus_state_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b01,
        PWR_SLEEP = 2'b10
    } wdp_power_t;

endpackage

`default_nettype wire

// >>> common/wdp_reg_if.sv
/*
 * Register access carrier between the bus slave and the register file.
 * Assumes both ends share clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

interface wdp_reg_if;
    logic wrEn;
    logic [7:0] wrIdx;
    logic [31:0] wrData;
    logic [7:0] rdIdx;
    logic [31:0] rdData;

    modport bus (output wrEn, output wrIdx, output wrData, output rdIdx,
                 input rdData);
    modport regs (input wrEn, input wrIdx, input wrData, input rdIdx,
                  output rdData);
endinterface

`default_nettype wire

// >>> rtl/wdp_prescaler.sv
/*
 * Shared prescaler as seen by the watchdog: divides oscillator ticks.
 * Assumes tickIn is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module wdp_prescaler
    import wdp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic tickIn,
    input wire logic clear,
    input wire logic assigned,
    input wire logic [RATIO_W-1:0] ratioSel,
    output logic tickOut
);

    logic [PRE_W-1:0] preCount_r;
    logic atLimit;

    // Last count of a 2^sel division
    function automatic logic [PRE_W-1:0] ratioLimit(
        input logic [RATIO_W-1:0] sel);
        logic [PRE_W:0] full;
        full = (8'h01 << sel) - 8'h01;
        return full[PRE_W-1:0];
    endfunction

    // A ratio lowered mid-count terminates at once, hence >=
    assign atLimit = preCount_r >= ratioLimit(ratioSel); // RULE10

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            preCount_r <= '0;
        end else if (clear) begin
            preCount_r <= '0; // RULE7
        end else if (tickIn && assigned) begin
            preCount_r <= atLimit ? '0 : preCount_r + 7'h01;
        end
    end

    assign tickOut = tickIn && (!assigned || atLimit); // RULE6 RULE10

endmodule

`default_nettype wire

// >>> rtl/wdp_ahb_slave.sv
/*
 * AHB-Lite slave front end: writes take no wait, reads one wait state.
 * Assumes single word transfers and that this is the only slave.
 */
`timescale 1ns/1ps
`default_nettype none

module wdp_ahb_slave
    import wdp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    wdp_reg_if.bus rif
);

    wdp_bus_state_t busState_r;
    wdp_bus_state_t busState_nxt;
    logic [7:0] idx_r;
    logic mapped_r;
    logic take;
    logic mapped;

    assign take = hsel && htrans[1] && hready;
    assign mapped = (haddr[31:10] == HADDR_HIGH_ZERO) &&
                    (haddr[1:0] == 2'h0) && (hsize == HSIZE_WORD);

    always_comb begin
        busState_nxt = BUS_IDLE;
        if (busState_r == BUS_RWAIT) begin
            busState_nxt = BUS_RDONE;
        end else if (take) begin
            busState_nxt = hwrite ? BUS_WRITE : BUS_RWAIT;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busState_r <= BUS_IDLE;
        end else begin
            busState_r <= busState_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idx_r <= 8'h00;
            mapped_r <= 1'b0;
        end else if (take) begin
            idx_r <= haddr[9:2];
            mapped_r <= mapped;
        end
    end

    // Sampled in the wait cycle so a preceding write is already visible
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h0;
        end else if (busState_r == BUS_RWAIT) begin
            hrdata <= mapped_r ? rif.rdData : 32'h0;
        end
    end

    assign rif.wrEn = (busState_r == BUS_WRITE) && mapped_r;
    assign rif.wrIdx = idx_r;
    assign rif.wrData = hwdata;
    assign rif.rdIdx = idx_r;
    assign hreadyout = (busState_r != BUS_RWAIT);
    assign hresp = 1'b0;

endmodule

`default_nettype wire

// >>> rtl/wdp_watchdog_top.sv
/*
 * Watchdog timer with shared prescaler, its registers and interrupt.
 * Assumes the RC oscillator arrives as a slow pin, sampled on clk_sys,
 * and that the core reports its clear and sleep instructions as pulses.
 */
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module wdp_watchdog_top
    import wdp_pkg::*;
#(
    parameter int unsigned BASE_TICKS_P = BASE_TICKS
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rcOscPin,
    input wire logic watchdogEnableFuse,
    input wire logic watchdogClearInstruction,
    input wire logic sleepInstruction,
    input wire logic coreWakeEvent,
    output logic watchdogResetReq,
    output logic watchdogWakeReq,
    output logic sleepActive,
    output logic timeoutFlagN,
    output logic irq
);

    localparam logic [31:0] LAST_COUNT = 32'(BASE_TICKS_P - 1);

    wdp_reg_if rif ();

    // Oscillator and fuse synchronisers
    logic rcSync1_r;
    logic rcSync2_r;
    logic rcSync3_r;
    logic rcEdge;
    logic fuseSync1_r;
    logic fuseSync2_r;
    logic [1:0] startup_r;
    logic fuseCaught_r;
    logic enabled_r;

    // Control register and prescaler
    logic [7:0] prescaleCtrl_r;
    logic prescalerAssignBit;
    logic [RATIO_W-1:0] ratioSelect;
    logic preClear;
    logic preTick;

    // Counter, power state and events
    logic [31:0] watchdogCounter_r;
    logic restart;
    logic timeout;
    wdp_power_t power_r;
    wdp_power_t power_nxt;
    logic timeoutFlagN_r;
    logic resetReq_r;
    logic wakeReq_r;

    // Interrupt registers
    logic [IRQ_W-1:0] irqStatus_r;
    logic [IRQ_W-1:0] irqMask_r;
    logic [IRQ_W-1:0] irqEvents;
    logic [IRQ_W-1:0] irqClear;

    wdp_ahb_slave u_bus (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rif(rif)
    );

    // Register write decode
    function automatic logic writeHit(
        input logic en,
        input logic [7:0] idx,
        input logic [7:0] target);
        return en && (idx == target);
    endfunction

    // Oscillator pin: two stages, then edge detect on settled samples
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rcSync1_r <= 1'b0;
            rcSync2_r <= 1'b0;
            rcSync3_r <= 1'b0;
        end else begin
            rcSync1_r <= rcOscPin;
            rcSync2_r <= rcSync1_r;
            rcSync3_r <= rcSync2_r;
        end
    end

    // Counts on oscillator edges, not on the stoppable core clock
    assign rcEdge = rcSync2_r && !rcSync3_r; // RULE1

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fuseSync1_r <= 1'b0;
            fuseSync2_r <= 1'b0;
        end else begin
            fuseSync1_r <= watchdogEnableFuse;
            fuseSync2_r <= fuseSync1_r;
        end
    end

    // Fuse is caught once after reset release; no register can change it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            startup_r <= 2'h0;
        end else if (startup_r != STARTUP_DONE) begin
            startup_r <= startup_r + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fuseCaught_r <= 1'b0;
            enabled_r <= 1'b0;
        end else if (!fuseCaught_r && startup_r == STARTUP_DONE) begin
            fuseCaught_r <= 1'b1;
            enabled_r <= fuseSync2_r; // RULE4
        end
    end

    // Prescale control register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prescaleCtrl_r <= PRESCALE_CTRL_RESET;
        end else if (writeHit(rif.wrEn, rif.wrIdx, IDX_PRESCALE_CTRL)) begin
            prescaleCtrl_r <= rif.wrData[7:0]; // RULE6
        end
    end

    assign prescalerAssignBit = prescaleCtrl_r[ASSIGN_BIT];
    assign ratioSelect = prescaleCtrl_r[RATIO_LSB +: RATIO_W];

    // Clear or sleep restarts the count
    assign restart = watchdogClearInstruction || sleepInstruction; // RULE7
    assign preClear = restart && prescalerAssignBit; // RULE7

    wdp_prescaler u_pre (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tickIn(rcEdge),
        .clear(preClear),
        .assigned(prescalerAssignBit),
        .ratioSel(ratioSelect),
        .tickOut(preTick)
    );

    // An instruction in the same cycle as the last tick wins over time-out
    assign timeout = enabled_r && preTick && !restart &&
                     (watchdogCounter_r == LAST_COUNT); // RULE5

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            watchdogCounter_r <= 32'h0;
        end else if (!enabled_r || restart) begin
            watchdogCounter_r <= 32'h0; // RULE7 RULE4
        end else if (timeout) begin
            watchdogCounter_r <= 32'h0;
        end else if (preTick) begin
            watchdogCounter_r <= watchdogCounter_r + 32'h1; // RULE1 RULE5
        end
    end

    // Run and sleep tracking
    always_comb begin
        power_nxt = power_r;
        unique case (power_r)
            PWR_RUN: begin
                if (sleepInstruction) begin
                    power_nxt = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (timeout || coreWakeEvent) begin
                    power_nxt = PWR_RUN; // RULE3
                end
            end
            default: begin
                power_nxt = PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            power_r <= PWR_RUN;
        end else begin
            power_r <= power_nxt;
        end
    end

    // Time-out consequence depends on power state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            resetReq_r <= 1'b0;
            wakeReq_r <= 1'b0;
        end else begin
            resetReq_r <= timeout && (power_r == PWR_RUN); // RULE2
            wakeReq_r <= timeout && (power_r == PWR_SLEEP); // RULE3
        end
    end

    // Active-low time-out flag; set again by clear or sleep
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timeoutFlagN_r <= 1'b1;
        end else if (timeout) begin
            timeoutFlagN_r <= 1'b0; // RULE8
        end else if (restart) begin
            timeoutFlagN_r <= 1'b1;
        end
    end

    // Sticky interrupt status; a new event beats a same-cycle clear
    assign irqEvents[IRQ_RESET] = timeout && (power_r == PWR_RUN);
    assign irqEvents[IRQ_WAKE] = timeout && (power_r == PWR_SLEEP);
    assign irqClear = writeHit(rif.wrEn, rif.wrIdx, IDX_IRQ_STATUS) ?
                      rif.wrData[IRQ_W-1:0] : IRQ_RESET_VAL;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irqStatus_r <= IRQ_RESET_VAL;
        end else begin
            irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvents;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irqMask_r <= IRQ_RESET_VAL;
        end else if (writeHit(rif.wrEn, rif.wrIdx, IDX_IRQ_MASK)) begin
            irqMask_r <= rif.wrData[IRQ_W-1:0];
        end
    end

    // Read multiplexer
    always_comb begin
        rif.rdData = 32'h0;
        unique case (rif.rdIdx)
            IDX_PRESCALE_CTRL: begin
                rif.rdData[7:0] = prescaleCtrl_r;
            end
            IDX_WD_STATUS: begin
                rif.rdData[ST_TIMEOUT_N] = timeoutFlagN_r;
                rif.rdData[ST_ASLEEP] = (power_r == PWR_SLEEP);
                rif.rdData[ST_ENABLED] = enabled_r;
            end
            IDX_IRQ_STATUS: begin
                rif.rdData[IRQ_W-1:0] = irqStatus_r;
            end
            IDX_IRQ_MASK: begin
                rif.rdData[IRQ_W-1:0] = irqMask_r;
            end
            IDX_COUNT: begin
                rif.rdData = watchdogCounter_r;
            end
            default: begin
                rif.rdData = 32'h0;
            end
        endcase
    end

    assign watchdogResetReq = resetReq_r;
    assign watchdogWakeReq = wakeReq_r;
    assign sleepActive = (power_r == PWR_SLEEP);
    assign timeoutFlagN = timeoutFlagN_r;
    assign irq = |(irqStatus_r & irqMask_r);

endmodule

`default_nettype wire

// >>> tb/wdp_watchdog_sva.sv
/*
 * Port checker of the watchdog top: bus waits, time-out pulses, flag.
 * Assumes it is bound into wdp_watchdog_top, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module wdp_watchdog_sva
#(
    parameter int unsigned BASE_TICKS_P = 4
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic watchdogEnableFuse,
    input wire logic watchdogClearInstruction,
    input wire logic sleepInstruction,
    input wire logic watchdogResetReq,
    input wire logic watchdogWakeReq,
    input wire logic sleepActive,
    input wire logic timeoutFlagN,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_read_one_wait: assert property (
        hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (
        hsel && htrans[1] && hready && hwrite |=> hreadyout)
        else $error("write stalled");
    a_reset_when_running: assert property (
        watchdogResetReq |-> !$past(sleepActive))
        else $error("reset request while asleep");
    a_reset_pulse_once: assert property (
        watchdogResetReq |=> !watchdogResetReq)
        else $error("reset request too long");
    a_wake_when_asleep: assert property (
        watchdogWakeReq |-> $past(sleepActive) ##[0:1] !sleepActive)
        else $error("wake request wrong");
    a_fuse_off_quiet: assert property (
        !watchdogEnableFuse |-> !watchdogResetReq && !watchdogWakeReq)
        else $error("time-out with fuse off");
    a_flag_with_req: assert property (
        watchdogResetReq || watchdogWakeReq
        |-> !timeoutFlagN || !$past(timeoutFlagN))
        else $error("flag not low at time-out");
    a_flag_falls_timeout: assert property (
        $fell(timeoutFlagN) |-> ##[0:2] (watchdogResetReq || watchdogWakeReq))
        else $error("flag fell without time-out");
    a_restart_sets_flag: assert property (
        watchdogClearInstruction || sleepInstruction |=> timeoutFlagN)
        else $error("restart left flag low");
    a_sleep_enters: assert property (
        sleepInstruction |=> sleepActive)
        else $error("sleep not entered");

    c_reset_req: cover property (watchdogResetReq);
    c_wake_req: cover property (watchdogWakeReq);
    c_irq: cover property (irq);
endmodule

bind wdp_watchdog_top wdp_watchdog_sva #(.BASE_TICKS_P(BASE_TICKS_P)) sva_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .watchdogEnableFuse(watchdogEnableFuse),
    .watchdogClearInstruction(watchdogClearInstruction),
    .sleepInstruction(sleepInstruction),
    .watchdogResetReq(watchdogResetReq), .watchdogWakeReq(watchdogWakeReq),
    .sleepActive(sleepActive), .timeoutFlagN(timeoutFlagN), .irq(irq));

`default_nettype wire

// >>> tb/watchdog_timer_with_prescaler_test.sv
/*
 * Self-checking bench of the watchdog top over AHB-Lite.
 * Assumes wdp_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer_with_prescaler_test;
    import wdp_pkg::*;
    localparam int unsigned BT = 4;
    localparam logic [31:0] A_CTRL = {22'h0, IDX_PRESCALE_CTRL, 2'h0};
    localparam logic [31:0] A_STAT = {22'h0, IDX_WD_STATUS, 2'h0};
    localparam logic [31:0] A_IRQ = {22'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [31:0] A_MASK = {22'h0, IDX_IRQ_MASK, 2'h0};
    localparam logic [31:0] A_CNT = {22'h0, IDX_COUNT, 2'h0};
    logic clk_sys = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic osc = 1'b0, fuse = 1'b1, clr = 1'b0, slp = 1'b0, wake = 1'b0;
    logic hreadyout, hresp, resetReq, wakeReq, asleep, flagN, irq;
    wire logic hready;
    int mismatches = 0, tests_run = 0, resetCnt = 0, wakeCnt = 0;

    assign hready = hreadyout;
    always #2 clk_sys = ~clk_sys;

    wdp_watchdog_top #(.BASE_TICKS_P(BT)) dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rcOscPin(osc), .watchdogEnableFuse(fuse),
        .watchdogClearInstruction(clr), .sleepInstruction(slp),
        .coreWakeEvent(wake), .watchdogResetReq(resetReq),
        .watchdogWakeReq(wakeReq), .sleepActive(asleep),
        .timeoutFlagN(flagN), .irq(irq));

    always @(posedge clk_sys) begin
        if (resetReq === 1'b1) resetCnt++;
        if (wakeReq === 1'b1) wakeCnt++;
    end

    task automatic final_report;
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Returns at the rising edge at which hready is sampled high
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin
            mismatches++;
            final_report();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check(hresp, 1'b0);
        @(negedge clk_sys);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(x, e);
    endtask

    // Core pulse: 0 clear, 1 sleep, 2 other wake source
    task automatic pulse(input int k);
        @(posedge clk_sys);
        clr <= (k == 0);
        slp <= (k == 1);
        wake <= (k == 2);
        @(posedge clk_sys);
        {clr, slp, wake} <= 3'h0;
        @(negedge clk_sys);
    endtask

    // Oscillator edges, then enough cycles for the synchroniser
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            osc <= 1'b1;
            repeat (3) @(posedge clk_sys);
            osc <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic t_reset_values;
        rdc(A_CTRL, 32'h0000_00ff);
        rdc(A_MASK, 32'h0);
        rdc(A_IRQ, 32'h0);
        rdc(A_STAT, 32'h0000_0005);
        wr(32'h0000_0300, 32'hffff_ffff);
        rdc(32'h0000_0300, 32'h0);
        rdc(A_CTRL, 32'h0000_00ff);
    endtask

    task automatic t_ratios;
        int base;
        for (int s = 0; s < 8; s++) begin
            pulse(0);
            wr(A_CTRL, {28'h0, 1'b1, 3'(s)});
            base = resetCnt;
            ticks((BT << s) - 1);
            rdc(A_CNT, BT - 1);
            check(resetCnt, base);
            ticks(1);
            check(resetCnt, base + 1);
            check(flagN, 1'b0);
        end
    endtask

    task automatic t_clear;
        int base;
        base = resetCnt;
        pulse(0);
        check(flagN, 1'b1);
        wr(A_CTRL, 32'h0000_0009);
        ticks(2 * BT - 1);
        pulse(0);
        ticks(2 * BT - 1);
        check(resetCnt, base);
        ticks(1);
        check(resetCnt, base + 1);
        wr(A_CTRL, 32'h0000_0007);
        pulse(0);
        ticks(BT - 1);
        rdc(A_CNT, BT - 1);
        ticks(1);
        check(resetCnt, base + 2);
    endtask

    task automatic t_sleep;
        int base;
        base = resetCnt;
        ticks(BT - 1);
        pulse(1);
        check(asleep, 1'b1);
        rdc(A_STAT, 32'h0000_0007);
        ticks(BT - 1);
        check(wakeCnt, 0);
        ticks(1);
        check(wakeCnt, 1);
        check(resetCnt, base);
        check(asleep, 1'b0);
        check(flagN, 1'b0);
        pulse(1);
        pulse(2);
        check(asleep, 1'b0);
    endtask

    task automatic t_irq;
        rdc(A_IRQ, 32'h0000_0003);
        check(irq, 1'b0);
        wr(A_MASK, 32'h0000_0002);
        check(irq, 1'b1);
        wr(A_IRQ, 32'h0000_0002);
        rdc(A_IRQ, 32'h0000_0001);
        check(irq, 1'b0);
        wr(A_MASK, 32'h0000_0001);
        check(irq, 1'b1);
        wr(A_IRQ, 32'h0000_0001);
        check(irq, 1'b0);
    endtask

    task automatic t_fuse;
        int base;
        @(posedge clk_sys);
        fuse <= 1'b0;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        base = resetCnt;
        rdc(A_STAT, 32'h0000_0001);
        wr(A_CTRL, 32'h0);
        ticks(2 * BT);
        check(resetCnt, base);
        rdc(A_CNT, 32'h0);
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_reset_values();
        t_ratios();
        t_clear();
        t_sleep();
        t_irq();
        t_fuse();
        final_report();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        final_report();
    end
endmodule

`default_nettype wire
